/* rtl/scia_pkg.sv */
package scia_pkg;
  // ************************************************************
  // sizes and field positions
  // ************************************************************
  localparam int SRC_N = 4; // index 0 has the highest priority
  localparam int IRQ_MODE_LO = 3; // interrupt mode field, bits 4:3
  localparam int DMA_MODE_LO = 0; // dma mode field, bits 1:0
  localparam int EOS_LO = 3; // end-of-service code, bits 5:3
  localparam logic [2:0] EOS_CODE = 3'h7;
  localparam logic [1:0] IRQ_MODE_FREE = 2'h3;
  localparam logic [1:0] DMA_NONE = 2'h0;
  localparam logic [1:0] DMA_CHAN_A = 2'h1;
  localparam logic [1:0] DMA_HOLD_CHAIN = 2'h2;
  localparam logic [1:0] DMA_DIRECT_ACK = 2'h3;
  localparam logic [3:0] CHAN_A_MASK = 4'h3; // rx a, tx a
  localparam logic [3:0] CHAN_B_MASK = 4'hc; // rx b, tx b

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] SRC_RST = 4'h0;
  localparam logic [3:0] REQ_N_RST = 4'hf;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {ACK_IDLE, ACK_FIRST, ACK_BETWEEN} scia_ack_e;

  // host strobes that always travel together
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_n;
  } scia_strobe_s;

  // ************************************************************
  // priority helpers
  // ************************************************************
  // one-hot of the highest-priority set bit
  function automatic logic [3:0] scia_top1(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(5'h1 << i);
      end
    end
    return r;
  endfunction : scia_top1

  // bits strictly above the highest set bit; all when none set
  function automatic logic [3:0] scia_above(input logic [3:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'((5'h1 << i) - 5'h1);
      end
    end
    return r;
  endfunction : scia_above
endpackage : scia_pkg

/* rtl/scia_arbiter.sv */
// Behaviour
// - chain priority high holds interrupt output inactive
// - resolve between ack falls, latch at second
// - in-service blocks and clears lower levels
// - end-of-service command clears highest in-service only
// - higher request still enabled over in-service one
// - chain out released only when all cleared
// - mode 11 interrupt output ignores chain priority input
// - nonvectored: latch at read fall of vector status
// - vector status selected blocks until read done
// - mode 11 is direct-ack dual dma
// - direct mode accepts outside read/write, unprioritised
// - mode 01 channel a only, 10 hold-chain
// - hold-chain acceptance windows and request pins
// - hold-ack trailing edge latches pending requests
// - read/write trailing edge clears serviced request
// - force selects while request out, hold low
// - internal ack state gates interrupt acceptance
// - enabled interrupt drives output low, chain high
`timescale 1ns/1ns
`default_nettype none
module scia_arbiter
  import scia_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] irq_pend_i,
  input wire logic [3:0] dma_req_i,
  input wire logic chain_priority_in_n_i,
  input wire logic ack_strobe_n_i,
  input wire scia_strobe_s strobe_i,
  input wire logic vec_stat_sel_i,
  input wire logic vectored_i,
  input wire logic cr0_wr_i,
  input wire logic [7:0] command_register_zero_i,
  input wire logic [7:0] channel_a_mode_register_i,
  input wire logic hold_ack_in_n_i,
  output logic irq_n_o,
  output logic irq_oe_n_o,
  output logic chain_priority_out_n_o,
  output logic [3:0] in_service_o,
  output logic [3:0] dma_request_line_n_o,
  output logic [3:0] dma_req_oe_n_o,
  output logic [3:0] dma_in_service_o,
  output logic force_cs_n_o,
  output logic force_cd_o,
  output logic force_chan_b_o
);

  // ************************************************************
  // edge detection
  // ************************************************************
  logic ack_prev_reg;
  logic rd_prev_reg;
  logic wr_prev_reg;
  logic hold_prev_reg;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      hold_prev_reg <= 1'b1;
    end else begin
      ack_prev_reg <= ack_strobe_n_i;
      rd_prev_reg <= strobe_i.rd_n;
      wr_prev_reg <= strobe_i.wr_n;
      hold_prev_reg <= hold_ack_in_n_i;
    end
  end

  logic ack_fall;
  logic ack_rise;
  logic rd_fall;
  logic rw_rise;
  logic rw_idle;
  logic hold_rise;
  assign ack_fall = ack_prev_reg && !ack_strobe_n_i;
  assign ack_rise = !ack_prev_reg && ack_strobe_n_i;
  assign rd_fall = rd_prev_reg && !strobe_i.rd_n;
  assign rw_rise = (!rd_prev_reg && strobe_i.rd_n) ||
                   (!wr_prev_reg && strobe_i.wr_n);
  assign rw_idle = strobe_i.rd_n && strobe_i.wr_n;
  assign hold_rise = !hold_prev_reg && hold_ack_in_n_i;

  logic [1:0] irq_mode;
  logic [1:0] dma_mode;
  logic eos_cmd;
  assign irq_mode = channel_a_mode_register_i[IRQ_MODE_LO +: 2];
  assign dma_mode = channel_a_mode_register_i[DMA_MODE_LO +: 2];
  assign eos_cmd = cr0_wr_i &&
    (command_register_zero_i[EOS_LO +: 3] == EOS_CODE);

  // ************************************************************
  // acknowledge sequence
  // ************************************************************
  scia_ack_e ack_state_reg;
  logic int_ack_reg;
  // the internal ack state spans the gap between the two strobes
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_state_reg <= ACK_IDLE;
      int_ack_reg <= 1'b0;
    end else begin
      case (ack_state_reg)
        ACK_IDLE: begin
          if (ack_fall) begin
            ack_state_reg <= ACK_FIRST;
          end
        end
        ACK_FIRST: begin
          if (ack_rise) begin
            ack_state_reg <= ACK_BETWEEN;
            int_ack_reg <= 1'b1;
          end
        end
        ACK_BETWEEN: begin
          if (ack_fall) begin
            ack_state_reg <= ACK_IDLE;
            int_ack_reg <= 1'b0;
          end
        end
        default: begin
          ack_state_reg <= ACK_IDLE;
          int_ack_reg <= 1'b0;
        end
      endcase
    end
  end

  logic ack_latch;
  assign ack_latch = (ack_state_reg == ACK_BETWEEN) && ack_fall;

  // ************************************************************
  // nonvectored read lock
  // ************************************************************
  logic nv_block_reg;
  logic nv_latch;
  assign nv_latch = !vectored_i && vec_stat_sel_i && rd_fall;
  // selecting vector status freezes arbitration until read ends
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      nv_block_reg <= 1'b0;
    end else if (!vectored_i && vec_stat_sel_i) begin
      nv_block_reg <= 1'b1;
    end else if (nv_block_reg && !rd_prev_reg && strobe_i.rd_n) begin
      nv_block_reg <= 1'b0;
    end
  end

  // ************************************************************
  // interrupt enable and in-service latches
  // ************************************************************
  logic [3:0] enabled_reg;
  logic [3:0] isr_reg;
  logic [3:0] enabled_next;
  logic [3:0] isr_next;
  logic hold_arb;
  // hold the winner while ack or the read lock is in progress
  assign hold_arb = int_ack_reg || nv_block_reg ||
                    (vec_stat_sel_i && !vectored_i);
  always_comb begin
    enabled_next = enabled_reg;
    if (!hold_arb) begin
      // only levels above the in-service one may win
      enabled_next = scia_top1(irq_pend_i & scia_above(isr_reg));
    end
  end

  always_comb begin
    isr_next = isr_reg;
    if (eos_cmd) begin
      isr_next = isr_reg & ~scia_top1(isr_reg);
    end
    // a new latch wins over a same-cycle end of service
    if ((ack_latch || nv_latch) && (|enabled_reg)) begin
      isr_next = enabled_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enabled_reg <= SRC_RST;
      isr_reg <= SRC_RST;
    end else begin
      enabled_reg <= enabled_next;
      isr_reg <= isr_next;
    end
  end

  // ************************************************************
  // interrupt pin and chain output
  // ************************************************************
  logic irq_active;
  always_comb begin
    if (irq_mode == IRQ_MODE_FREE) begin
      irq_active = |irq_pend_i;
    end else begin
      irq_active = (|enabled_next) && !chain_priority_in_n_i;
    end
  end

  // pin only sinks; a released pin relies on the pull-up
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_n_o <= 1'b1;
      irq_oe_n_o <= 1'b1;
      chain_priority_out_n_o <= 1'b0;
      in_service_o <= SRC_RST;
    end else begin
      irq_n_o <= !irq_active;
      irq_oe_n_o <= !irq_active;
      chain_priority_out_n_o <= chain_priority_in_n_i ||
        (|irq_pend_i) || (|isr_next) || (|enabled_next);
      in_service_o <= isr_next;
    end
  end

  // ************************************************************
  // dma request acceptance and service
  // ************************************************************
  logic [3:0] dma_mask;
  logic [3:0] dma_acc_reg;
  logic [3:0] dma_isr_reg;
  logic [3:0] dma_acc_next;
  logic [3:0] dma_isr_next;
  logic [3:0] dma_serv;
  logic hold_chain;
  always_comb begin
    case (dma_mode)
      DMA_CHAN_A: dma_mask = CHAN_A_MASK;
      DMA_HOLD_CHAIN: dma_mask = CHAN_A_MASK | CHAN_B_MASK;
      DMA_DIRECT_ACK: dma_mask = CHAN_A_MASK | CHAN_B_MASK;
      default: dma_mask = 4'h0;
    endcase
  end
  assign hold_chain = (dma_mode == DMA_CHAN_A) ||
                      (dma_mode == DMA_HOLD_CHAIN);
  // latched requests first, else the best accepted one
  assign dma_serv = (|dma_isr_reg) ? scia_top1(dma_isr_reg) :
                    scia_top1(dma_acc_reg);

  always_comb begin
    dma_acc_next = dma_acc_reg & dma_mask;
    dma_isr_next = dma_isr_reg & dma_mask;
    if (dma_mode == DMA_DIRECT_ACK) begin
      dma_isr_next = 4'h0;
      if (rw_idle) begin
        dma_acc_next = dma_req_i & dma_mask;
      end
    end else if (hold_chain) begin
      if ((hold_ack_in_n_i && rw_idle) ||
          (!hold_ack_in_n_i && rw_rise)) begin
        dma_acc_next = dma_req_i & dma_mask;
      end
      if (!hold_ack_in_n_i && rw_rise) begin
        dma_acc_next = dma_acc_next & ~dma_serv;
        dma_isr_next = dma_isr_reg & ~dma_serv;
      end
      if (hold_rise) begin
        dma_isr_next = dma_isr_next | dma_acc_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dma_acc_reg <= SRC_RST;
      dma_isr_reg <= SRC_RST;
    end else begin
      dma_acc_reg <= dma_acc_next;
      dma_isr_reg <= dma_isr_next;
    end
  end

  // request pins and internal select forcing
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dma_request_line_n_o <= REQ_N_RST;
      dma_req_oe_n_o <= REQ_N_RST;
      dma_in_service_o <= SRC_RST;
      force_cs_n_o <= 1'b1;
      force_cd_o <= 1'b1;
      force_chan_b_o <= 1'b0;
    end else begin
      dma_request_line_n_o <= ~dma_acc_next;
      dma_req_oe_n_o <= ~dma_acc_next;
      dma_in_service_o <= dma_isr_next;
      force_cs_n_o <= !(hold_chain && (|dma_acc_next) &&
                        !hold_ack_in_n_i);
      force_cd_o <= !(hold_chain && (|dma_acc_next) &&
                      !hold_ack_in_n_i);
      force_chan_b_o <= |(dma_serv & CHAN_B_MASK);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  pri_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    chain_priority_in_n_i && (irq_mode != IRQ_MODE_FREE) |=> irq_n_o)
    else $error("interrupt asserted while chain priority high");

  ack_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ack_latch && (|enabled_reg) |=> in_service_o == $past(enabled_reg))
    else $error("in-service not latched at second ack fall");

  isr_single_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $onehot0(in_service_o))
    else $error("lower in-service latch left set");

  eos_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    eos_cmd && !ack_latch && !nv_latch |=> in_service_o == 4'h0)
    else $error("end of service did not clear latch");

  free_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (irq_mode == IRQ_MODE_FREE) && (|irq_pend_i) |=> !irq_n_o && !irq_oe_n_o)
    else $error("free mode interrupt not driven");

  chain_rel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !chain_priority_out_n_o && $past(reset_n_i) |->
    $past(irq_pend_i) == 4'h0 &&
    in_service_o == 4'h0)
    else $error("chain released with work outstanding");

  nv_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    nv_block_reg && $past(nv_block_reg) |-> $stable(enabled_reg))
    else $error("arbitration moved during read lock");

  direct_acc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (dma_mode == DMA_DIRECT_ACK) && rw_idle |=>
    dma_request_line_n_o == ~$past(dma_req_i))
    else $error("direct mode request not accepted");

  force_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hold_chain && !hold_ack_in_n_i && (dma_acc_next != 4'h0) |=>
    !force_cs_n_o && !force_cd_o)
    else $error("selects not forced during dma cycle");

  dma_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hold_chain && !hold_ack_in_n_i && rw_rise |=>
    (dma_in_service_o & $past(dma_serv)) == 4'h0)
    else $error("serviced dma request not cleared");
endmodule : scia_arbiter
`default_nettype wire

/* bench/scia_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// far side: host strobes and dma hold grant
// ************************************************************
module scia_far_model
  import scia_pkg::*;
(
  input wire logic clk_i,
  output var scia_strobe_s strobe_o,
  output var logic ack_strobe_n_o,
  output var logic hold_ack_in_n_o
);
  // idle levels; chip select is never pulled low by this side
  initial begin
    strobe_o = '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
    ack_strobe_n_o = 1'b1;
    hold_ack_in_n_o = 1'b1;
  end

  // fall, rise, fall, rise; each level held two cycles
  task automatic ack_cycle();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      ack_strobe_n_o = i[0];
      @(negedge clk_i);
    end
  endtask : ack_cycle

  // one read or write strobe, low for two cycles
  task automatic rw_pulse(input logic wr);
    @(negedge clk_i);
    if (wr) begin
      strobe_o.wr_n = 1'b0;
    end else begin
      strobe_o.rd_n = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    strobe_o.rd_n = 1'b1;
    strobe_o.wr_n = 1'b1;
  endtask : rw_pulse

  // hold grant level, changed off the sampling edge
  task automatic set_hold(input logic v);
    @(negedge clk_i);
    hold_ack_in_n_o = v;
  endtask : set_hold
endmodule : scia_far_model
`default_nettype wire

/* bench/test_serial_ctrl_irq_dma_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module test_serial_ctrl_irq_dma_arbiter;
  import scia_pkg::*;
  logic clk, reset_n, pri_n, vsel, vec, cr0_wr, ack_n, hold_n;
  logic [3:0] pend, dreq;
  logic [7:0] cr0, mode;
  scia_strobe_s strobe;
  logic irq_n, irq_oe_n, chain_n, fcs, fcd, fchb;
  logic [3:0] isr, dpin, doe, disr;
  logic [3:0] irqv, fv;
  int num_errors = 0;
  int num_checks = 0;
  assign irqv = {1'b0, irq_n, irq_oe_n, chain_n};
  assign fv = {1'b0, fcs, fcd, fchb};

  // ************************************************************
  // clock, instances
  // ************************************************************
  initial clk = 1'b0;
  always #10 clk = ~clk;

  scia_arbiter scia_arbiter_i (
    .clk_i(clk), .reset_n_i(reset_n), .irq_pend_i(pend),
    .dma_req_i(dreq), .chain_priority_in_n_i(pri_n),
    .ack_strobe_n_i(ack_n), .strobe_i(strobe),
    .vec_stat_sel_i(vsel), .vectored_i(vec), .cr0_wr_i(cr0_wr),
    .command_register_zero_i(cr0), .channel_a_mode_register_i(mode),
    .hold_ack_in_n_i(hold_n), .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n),
    .chain_priority_out_n_o(chain_n), .in_service_o(isr),
    .dma_request_line_n_o(dpin), .dma_req_oe_n_o(doe),
    .dma_in_service_o(disr), .force_cs_n_o(fcs), .force_cd_o(fcd),
    .force_chan_b_o(fchb)
  );

  scia_far_model scia_far_model_i (
    .clk_i(clk), .strobe_o(strobe), .ack_strobe_n_o(ack_n),
    .hold_ack_in_n_o(hold_n)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic st(input int n);
    repeat (n) @(negedge clk);
  endtask : st

  task automatic chk(input string nm, input logic [3:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request pins and their drive enables move together
  task automatic dm(input logic [3:0] e);
    chk("dma pins", dpin, e);
    chk("dma oe", doe, e);
  endtask : dm

  // one-cycle command write
  task automatic cmd(input logic [7:0] d);
    cr0 = d;
    cr0_wr = 1'b1;
    st(1);
    cr0_wr = 1'b0;
    st(2);
  endtask : cmd

  // input setters: interrupt, dma and vector-select stimulus each pass through one place
  task automatic irq_in(input logic [3:0] p, input logic pr);
    pend = p;
    pri_n = pr;
  endtask : irq_in

  task automatic dma_in(input logic [7:0] m, input logic [3:0] d);
    mode = m;
    dreq = d;
  endtask : dma_in

  task automatic nv_in(input logic v, input logic s);
    vec = v;
    vsel = s;
  endtask : nv_in

  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // watchdog: a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("MISMATCH watchdog exp done seen hang");
    final_report();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {cr0_wr, cr0} = '0;
    irq_in(4'h0, 1'b0);
    dma_in(8'h00, 4'h0);
    nv_in(1'b1, 1'b0);
    reset_n = 1'b0;
    st(8);
    chk("rst irq", irqv, 4'h6);
    chk("rst isr", isr, 4'h0);
    dm(4'hf);
    chk("rst force", fv, 4'h6);
    reset_n = 1'b1;
    // chain input high gates the interrupt except in free mode
    irq_in(4'h4, 1'b1);
    for (int i = 0; i < 3; i++) begin
      dma_in({3'h0, (i == 2) ? 2'h3 : 2'(i), 3'h0}, dreq);
      st(3);
      chk("irq mode", irqv, (i == 2) ? 4'h1 : 4'h7);
    end
    dma_in(8'h00, dreq);
    irq_in(pend, 1'b0);
    st(2);
    chk("irq on", irqv, 4'h1);
    scia_far_model_i.ack_cycle();
    st(2);
    chk("isr ack", isr, 4'h4);
    irq_in(4'h8, pri_n);
    st(3);
    chk("irq lower", irqv, 4'h7);
    irq_in(4'h9, pri_n);
    st(2);
    chk("irq higher", irqv, 4'h1);
    scia_far_model_i.ack_cycle();
    st(2);
    chk("isr higher", isr, 4'h1);
    irq_in(4'h0, pri_n);
    cmd(8'h30);
    chk("isr no eos", isr, 4'h1);
    cmd(8'h38);
    chk("isr eos", isr, 4'h0);
    chk("chain free", irqv, 4'h6);
    // nonvectored: select blocks until a read completes
    nv_in(1'b0, 1'b1);
    st(1);
    irq_in(4'h2, pri_n);
    st(3);
    chk("irq lock", irqv, 4'h7);
    scia_far_model_i.rw_pulse(1'b0);
    nv_in(vec, 1'b0);
    st(2);
    chk("irq nv", irqv, 4'h1);
    nv_in(vec, 1'b1);
    scia_far_model_i.rw_pulse(1'b0);
    st(2);
    chk("isr nv", isr, 4'h2);
    nv_in(vec, 1'b0);
    irq_in(4'h0, pri_n);
    cmd(8'h38);
    nv_in(1'b1, vsel);
    // dma mode field: none, channel a only, hold chain, direct
    dma_in(mode, 4'h5);
    for (int i = 0; i < 4; i++) begin
      dma_in(8'(i), dreq);
      st(2);
      dm((i == 0) ? 4'hf : (i == 1) ? 4'he : 4'ha);
    end
    dma_in(mode, 4'h1);
    st(2);
    dm(4'he);
    // requests are not taken while a read is in progress
    fork
      scia_far_model_i.rw_pulse(1'b0);
      begin
        st(1);
        dma_in(mode, 4'hf);
      end
    join
    dm(4'he);
    st(2);
    dm(4'h0);
    scia_far_model_i.set_hold(1'b0);
    st(2);
    chk("force direct", fv, 4'h6);
    scia_far_model_i.set_hold(1'b1);
    // let the grant rise land in direct mode, so nothing is latched
    st(1);
    // hold chain: requests dropped in internal order, as required
    dma_in(8'h02, 4'h5);
    st(2);
    dm(4'ha);
    scia_far_model_i.set_hold(1'b0);
    st(2);
    chk("force a", fv, 4'h0);
    dma_in(mode, 4'h7);
    st(2);
    dm(4'ha);
    dma_in(mode, 4'h6);
    scia_far_model_i.rw_pulse(1'b0);
    st(2);
    dm(4'h9);
    chk("force a2", fv, 4'h0);
    dma_in(mode, 4'h4);
    scia_far_model_i.rw_pulse(1'b1);
    st(2);
    dm(4'hb);
    chk("force b", fv, 4'h1);
    scia_far_model_i.set_hold(1'b1);
    st(2);
    chk("dma isr", disr, 4'h4);
    chk("force off", fv, 4'h7);
    scia_far_model_i.set_hold(1'b0);
    dma_in(mode, 4'h0);
    scia_far_model_i.rw_pulse(1'b1);
    st(2);
    chk("dma isr clr", disr, 4'h0);
    dm(4'hf);
    final_report();
  end
endmodule : test_serial_ctrl_irq_dma_arbiter
`default_nettype wire
